// ### src/spm_port.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "spm_regs.svh"
// Overview of operation
// - Bits travel most significant first on both data lines.
// - As master, MOSI is driven from the shift register top bit.
// - MISO floats when disabled or when an unselected 4-wire slave.
// - A 3-wire slave always drives MISO from the shift register top.
// - An unselected 4-wire slave ignores all SCK activity.
// - Select mode 00: 3-wire, select unused, slave always selected.
// - Select mode 01: select is input; falling select stops master.
// - Select mode 1x: select is an output equal to the low mode bit.
// - Select routed to a pin in every mode except 3-wire.
// - Setting the master enable bit enters master mode.
// - Data write loads transmit buffer; empty shifter takes it, starts.
// - A master transfer shifts out at once while driving SCK.
// - Each transfer end sets the done flag; interrupt when enabled.
// - Done flag means both sent and received; slave shifts alongside.
// - A full received byte moves to the receive buffer, unless a slave's is still full: overrun set.
// - Select mode resets to multi-master, high bit 0, low bit 1.
// - Low select on a multi-master master clears enables, sets mode fault.
// - Phase and polarity pick four clockings; both ends must agree.
// - Data write while buffer still full is dropped; collision set.
module spm_port
  import spm_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spm_pins_t pin_i,
  output spm_pins_t pin_o,
  output spm_pins_t pin_oe_n,
  output logic ss_routed,
  output logic irq
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DATA_W != 8) begin : g_bad_width
    $error("spm_port supports only 8-bit bytes");
  end
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  spm_pins_t s1_q, s2_q, po_q, poe_q;
  logic sck_prev_q, ss_prev_q;
  logic en_q, mst_q, cpha_q, cpol_q, irqen_q;
  logic [1:0] smd_q;
  logic [7:0] rate_q, div_q;
  logic done_q, write_collision_flag_q, mode_fault_flag_q, ovrn_q;
  logic [7:0] txbuf_q, tx_sh_q, rx_sh_q, rxbuf_q;
  logic txfull_q, sh_empty_q, rxfull_q;
  spm_state_t st_q;
  logic sck_q;
  logic [3:0] tog_q;
  logic [2:0] cnt_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, route_q, irq_q;
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire acc = psel & penable & pready_q;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_ctrl = paddr == `SPM_OFS_CTRL;
  wire hit_cfg = paddr == `SPM_OFS_CFG;
  wire hit_data = paddr == `SPM_OFS_DATA;
  wire hit_rate = paddr == `SPM_OFS_RATE;
  wire mapped = hit_ctrl | hit_cfg | hit_data | hit_rate;
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_cfg = wr & hit_cfg;
  wire wr_data = wr & hit_data;
  wire rd_data = rd & hit_data;
  // ----------------------------------------------------------------
  // Selection, edges and transfer events
  // ----------------------------------------------------------------
  wire busy = st_q == SPM_BUSY;
  wire ss_s = s2_q.ss;
  wire mmode = smd_q == 2'h1;
  wire slave_sel = ~mmode | ~ss_s;
  wire slv_act = en_q & ~mst_q & slave_sel;
  wire fault = en_q & mst_q & mmode & ~ss_s;
  wire ss_fall = mmode & ss_prev_q & ~ss_s;
  wire m_edge = en_q & mst_q & busy & (div_q == rate_q);
  wire m_lead = sck_q == cpol_q;
  wire s_edge = slv_act & (s2_q.sck != sck_prev_q);
  wire s_lead = sck_prev_q == cpol_q;
  wire edge_ev = mst_q ? m_edge : s_edge;
  wire lead = mst_q ? m_lead : s_lead;
  wire sample = edge_ev & (lead != cpha_q);
  wire launch = edge_ev & (lead == cpha_q);
  // Shifting only inside a frame keeps a reloaded byte whole
  wire shift_tx = launch & busy & ~(cpha_q & (cnt_q == 3'h0));
  wire in_bit = mst_q ? s2_q.miso : s2_q.mosi;
  wire [7:0] rx_next = sample ? {rx_sh_q[6:0], in_bit} : rx_sh_q;
  wire m_fin = m_edge & (tog_q == `SPM_LAST_TOGGLE);
  wire s_fin = ~mst_q & sample & (cnt_q == `SPM_LAST_BIT);
  wire fin = m_fin | s_fin;
  wire load = en_q & txfull_q & sh_empty_q & ~busy;
  wire m_start = load & mst_q;
  wire keep_rx = mst_q | ~rxfull_q;
  wire write_collision_flag_set = wr_data & txfull_q;
  wire ovrn_set = fin & ~keep_rx;
  wire ctl_clr = wr_ctrl;
  // Control register view
  wire [7:0] ctrl_v = {done_q, write_collision_flag_q, mode_fault_flag_q, ovrn_q, smd_q, irqen_q,
                       en_q};
  // Configuration and status view
  wire [7:0] cfg_v = {busy, mst_q, cpha_q, cpol_q, slv_act, ss_s,
                      sh_empty_q, ~rxfull_q};
  wire [7:0] rd_v = hit_ctrl ? ctrl_v : hit_cfg ? cfg_v :
                    hit_data ? rxbuf_q : hit_rate ? rate_q : 8'h00;
  // Pin drive values and enables
  spm_pins_t po_d, poe_d;
  assign po_d = '{sck: sck_q, mosi: tx_sh_q[7], miso: tx_sh_q[7],
                  ss: smd_q[0]};
  assign poe_d = '{sck: ~(en_q & mst_q), mosi: ~(en_q & mst_q),
                   miso: ~slv_act, ss: ~smd_q[1]};
  // ----------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss: 1'b1};
      s2_q <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss: 1'b1};
      sck_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      sck_prev_q <= s2_q.sck;
      ss_prev_q <= s2_q.ss;
    end
  end
  // ----------------------------------------------------------------
  // Software registers and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      en_q <= 1'b0;
      mst_q <= 1'b0;
      cpha_q <= 1'b0;
      cpol_q <= 1'b0;
      irqen_q <= 1'b0;
      smd_q <= `SPM_RST_SMD;
      rate_q <= `SPM_RST_RATE;
    end else begin
      if (fault) begin
        en_q <= 1'b0;
        mst_q <= 1'b0;
      end else begin
        if (wr_ctrl) en_q <= pwdata[`SPM_CTRL_EN];
        if (wr_cfg) mst_q <= pwdata[`SPM_CFG_MST];
      end
      if (wr_ctrl) begin
        irqen_q <= pwdata[`SPM_CTRL_IRQEN];
        smd_q <= pwdata[`SPM_CTRL_SMD_HI:`SPM_CTRL_SMD_LO];
      end
      if (wr_cfg) begin
        cpha_q <= pwdata[`SPM_CFG_CPHA];
        cpol_q <= pwdata[`SPM_CFG_CPOL];
      end
      if (wr & hit_rate) rate_q <= pwdata[7:0];
    end
  end
  // Sticky flags: writing 0 clears, a same-cycle set wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      ovrn_q <= 1'b0;
    end else begin
      done_q <= fin | (done_q & ~(ctl_clr & ~pwdata[`SPM_CTRL_DONE]));
      write_collision_flag_q <= write_collision_flag_set | (write_collision_flag_q & ~(ctl_clr & ~pwdata[`SPM_CTRL_WRITE_COLLISION_FLAG]));
      mode_fault_flag_q <= fault | (mode_fault_flag_q & ~(ctl_clr & ~pwdata[`SPM_CTRL_MODE_FAULT_FLAG]));
      ovrn_q <= ovrn_set | (ovrn_q & ~(ctl_clr & ~pwdata[`SPM_CTRL_OVRN]));
    end
  end
  // ----------------------------------------------------------------
  // Transmit buffer, shift registers and receive buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txbuf_q <= 8'h00;
      txfull_q <= 1'b0;
      tx_sh_q <= 8'h00;
      sh_empty_q <= 1'b1;
      rx_sh_q <= 8'h00;
      rxbuf_q <= 8'h00;
      rxfull_q <= 1'b0;
    end else begin
      if (load) begin
        tx_sh_q <= txbuf_q;
        sh_empty_q <= 1'b0;
      end else if (shift_tx) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
      if (fin) sh_empty_q <= 1'b1;
      if (wr_data & ~txfull_q) txbuf_q <= pwdata[7:0];
      txfull_q <= (wr_data & ~txfull_q) | (txfull_q & ~load);
      rx_sh_q <= rx_next;
      if (fin & keep_rx) rxbuf_q <= rx_next;
      rxfull_q <= (fin & keep_rx) | (rxfull_q & ~rd_data);
    end
  end
  // ----------------------------------------------------------------
  // Transfer engine: master clock, bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= SPM_IDLE;
      sck_q <= 1'b0;
      div_q <= 8'h00;
      tog_q <= 4'h0;
      cnt_q <= 3'h0;
    end else if (!en_q || fault || (!mst_q && ss_fall)) begin
      st_q <= SPM_IDLE;
      sck_q <= cpol_q;
      div_q <= 8'h00;
      tog_q <= 4'h0;
      cnt_q <= 3'h0;
    end else begin
      case (st_q)
        SPM_IDLE: begin
          sck_q <= cpol_q;
          div_q <= 8'h00;
          tog_q <= 4'h0;
          // A slave frame opens on a leading edge only
          if (m_start || (s_edge && s_lead)) st_q <= SPM_BUSY;
        end
        SPM_BUSY: begin
          if (mst_q) begin
            div_q <= m_edge ? 8'h00 : div_q + 8'h01;
            if (m_edge) begin
              sck_q <= ~sck_q;
              tog_q <= tog_q + 4'h1;
            end
          end
          if (fin) st_q <= SPM_IDLE;
        end
        default: st_q <= SPM_IDLE;
      endcase
      if (sample) cnt_q <= cnt_q + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // Registered outputs: pins, bus answer, request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      po_q <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, ss: 1'b1};
      poe_q <= '{sck: 1'b1, mosi: 1'b1, miso: 1'b1, ss: 1'b1};
      route_q <= 1'b1;
      irq_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      po_q <= po_d;
      poe_q <= poe_d;
      route_q <= smd_q != 2'h0;
      irq_q <= irqen_q & (done_q | write_collision_flag_q | mode_fault_flag_q | ovrn_q);
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~mapped;
      prdata_q <= {24'h0, rd_v};
    end
  end
  assign pin_o = po_q;
  assign pin_oe_n = poe_q;
  assign ss_routed = route_q;
  assign irq = irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [3:0] ecnt_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) ecnt_q <= 4'h0;
    else if (m_start) ecnt_q <= 4'h0;
    else if (m_edge) ecnt_q <= ecnt_q + 4'h1;
  end
  sequence s_start;
    m_start;
  endsequence
  sequence s_running;
    busy && !txfull_q;
  endsequence
  a_miso_float: assert property (!en_q |=> pin_oe_n.miso)
    else $error("MISO driven while disabled");
  a_mosi_drive: assert property (en_q && mst_q |=>
    !pin_oe_n.mosi && pin_o.mosi == $past(tx_sh_q[7]))
    else $error("MOSI not driven from shifter top");
  a_ss_output: assert property (smd_q[1] |=>
    !pin_oe_n.ss && pin_o.ss == $past(smd_q[0]))
    else $error("Select output wrong");
  a_fault_clears: assert property (fault |=>
    !en_q && !mst_q && mode_fault_flag_q)
    else $error("Mode fault did not disable port");
  a_write_collision_flag_drop: assert property (write_collision_flag_set |=>
    write_collision_flag_q && txbuf_q == $past(txbuf_q))
    else $error("Colliding write not dropped");
  a_start_xfer: assert property (s_start |=> s_running)
    else $error("Buffer did not start transfer");
  a_eight_clocks: assert property (m_fin |-> ecnt_q == 4'hf)
    else $error("Master transfer not eight clocks");
  a_done_set: assert property (fin |=> done_q && !busy)
    else $error("Done flag not set at end");
  a_rx_load: assert property (fin && keep_rx |=>
    rxbuf_q == $past(rx_next) && rxfull_q)
    else $error("Received byte not buffered");
  a_slave_ignore: assert property (!mst_q && mmode && ss_s |->
    !s_edge)
    else $error("Unselected slave saw SCK");
  a_msb_first: assert property (shift_tx && !load |=>
    tx_sh_q == {$past(tx_sh_q[6:0]), 1'b0})
    else $error("Shift not MSB first");
endmodule

// ### common/spm_regs.svh
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define SPM_OFS_CTRL 8'h00
`define SPM_OFS_CFG 8'h04
`define SPM_OFS_DATA 8'h08
`define SPM_OFS_RATE 8'h0c
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SPM_CTRL_DONE 7
`define SPM_CTRL_WRITE_COLLISION_FLAG 6
`define SPM_CTRL_MODE_FAULT_FLAG 5
`define SPM_CTRL_OVRN 4
`define SPM_CTRL_SMD_HI 3
`define SPM_CTRL_SMD_LO 2
`define SPM_CTRL_IRQEN 1
`define SPM_CTRL_EN 0
// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define SPM_CFG_BUSY 7
`define SPM_CFG_MST 6
`define SPM_CFG_CPHA 5
`define SPM_CFG_CPOL 4
`define SPM_CFG_SLVSEL 3
`define SPM_CFG_SSIN 2
`define SPM_CFG_SHEMPTY 1
`define SPM_CFG_RXEMPTY 0
// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SPM_RST_SMD 2'h1
`define SPM_RST_RATE 8'h00
`define SPM_LAST_TOGGLE 4'hf
`define SPM_LAST_BIT 3'h7
`endif

// ### common/spm_pkg.sv
// ----------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------
package spm_pkg;
  // One bit per serial pin
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } spm_pins_t;
  // Transfer engine state
  typedef enum logic {SPM_IDLE, SPM_BUSY} spm_state_t;
endpackage

// ### test/spm_slave_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Behavioural SPI slave, clock mode 0, on the far side of the port
// ----------------------------------------------------------------
module spm_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  int cnt;
  // Defined levels from time zero
  initial begin
    miso = 1'b0;
    sh = 8'h00;
    cnt = 0;
    rx_byte = 8'h00;
  end
  // Selection loads the reply and shows its top bit at once
  always @(negedge sel_n) begin
    sh = tx_byte;
    cnt = 0;
    miso = sh[7];
  end
  // A released line must not keep its last level
  always @(posedge sel_n) begin
    miso = ~miso;
  end
  // Leading edge samples MOSI; the eighth one ends a byte
  always @(posedge sck) begin
    if (!sel_n) begin
      sh = {sh[6:0], mosi};
      cnt = cnt + 1;
      if (cnt == 8) begin
        rx_byte = sh;
        sh = tx_byte;
        cnt = 0;
      end
    end
  end
  // Trailing edge presents the next bit
  always @(negedge sck) begin
    if (!sel_n) begin
      miso = sh[7];
    end
  end
endmodule

// ### test/spm_port_test.sv
`timescale 1ns/1ns
`include "spm_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module spm_port_test
  import spm_pkg::*;
;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, m_rx, got;
  logic [31:0] pwdata, prdata, rdat;
  logic ss_routed, irq, tb_sck, tb_mosi, tb_ss, m_miso;
  logic sck_w, mosi_w, miso_w, ss_w;
  spm_pins_t pin_i, pin_o, pin_oe_n;
  int n_fail, cmp_count, cyc, rises;
  // ----------------------------------------------------------------
  // Pin resolution, clock and partner
  // ----------------------------------------------------------------
  // Each line shows whoever drives it
  assign sck_w = pin_oe_n.sck ? tb_sck : pin_o.sck;
  assign mosi_w = pin_oe_n.mosi ? tb_mosi : pin_o.mosi;
  assign miso_w = pin_oe_n.miso ? m_miso : pin_o.miso;
  assign ss_w = pin_oe_n.ss ? tb_ss : pin_o.ss;
  assign pin_i = {sck_w, mosi_w, miso_w, ss_w};
  // System clock, 100 ns period
  always #50 clk_sys = ~clk_sys;
  spm_port dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .ss_routed(ss_routed), .irq(irq));
  spm_slave_model partner (.sck(sck_w), .mosi(mosi_w), .sel_n(ss_w),
    .tx_byte(8'h3c), .miso(m_miso), .rx_byte(m_rx));
  // Counts SCK rising edges on the wire
  always @(posedge sck_w) begin
    rises++;
  end
  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; read data and error land in rdat and rerr
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Access phase lasts until pready; only the hang guard ends a wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls the done flag under a bound
  task automatic wait_done;
    int k;
    k = 0;
    do begin
      apb(1'b0, `SPM_OFS_CTRL, 32'h0);
      k++;
    end while (rdat[7] !== 1'b1 && k < 100);
    if (k >= 100) begin
      n_fail++;
      final_report();
    end
  endtask
  // Bench acts as master: one byte at an 800 ns SCK, MSB first
  // MISO is taken late in the high phase: port pins lag SCK a few cycles
  task automatic slv_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      tb_mosi <= b[i];
      repeat (4) @(posedge clk_sys);
      tb_sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      got[i] = miso_w;
      tb_sck <= 1'b0;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {tb_sck, tb_mosi, tb_ss} = 3'b001;
    {n_fail, cmp_count, cyc, rises} = '0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    `CHK(pin_oe_n, 4'hf)
    `CHK(ss_routed, 1'b1)
    apb(1'b0, `SPM_OFS_CTRL, 32'h0);
    `CHK(rdat[7:0], 8'h04)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    // Master, select driven low, one byte
    apb(1'b1, `SPM_OFS_RATE, 32'h4);
    apb(1'b1, `SPM_OFS_CFG, 32'h40);
    apb(1'b1, `SPM_OFS_CTRL, 32'h0b);
    repeat (3) @(posedge clk_sys);
    `CHK({pin_oe_n.ss, pin_o.ss}, 2'b00)
    `CHK({pin_oe_n.sck, pin_oe_n.mosi}, 2'b00)
    rises = 0;
    apb(1'b1, `SPM_OFS_DATA, 32'ha5);
    wait_done();
    `CHK(rises, 8)
    `CHK(m_rx, 8'ha5)
    `CHK(irq, 1'b1)
    apb(1'b0, `SPM_OFS_DATA, 32'h0);
    `CHK(rdat[7:0], 8'h3c)
    // Buffered second byte, third write collides
    apb(1'b1, `SPM_OFS_CTRL, 32'h0b);
    apb(1'b1, `SPM_OFS_DATA, 32'h11);
    apb(1'b1, `SPM_OFS_DATA, 32'h22);
    apb(1'b1, `SPM_OFS_DATA, 32'h33);
    apb(1'b0, `SPM_OFS_CTRL, 32'h0);
    `CHK(rdat[6], 1'b1)
    wait_done();
    `CHK(m_rx, 8'h11)
    apb(1'b1, `SPM_OFS_CTRL, 32'h0b);
    wait_done();
    `CHK(m_rx, 8'h22)
    apb(1'b0, `SPM_OFS_DATA, 32'h0);
    `CHK(rdat[7:0], 8'h3c)
    // Master in clock mode 3, port disabled while the clocking changes
    apb(1'b1, `SPM_OFS_CTRL, 32'h0c);
    apb(1'b1, `SPM_OFS_CFG, 32'h70);
    apb(1'b1, `SPM_OFS_CTRL, 32'h0f);
    apb(1'b1, `SPM_OFS_CTRL, 32'h0b);
    rises = 0;
    apb(1'b1, `SPM_OFS_DATA, 32'hc3);
    wait_done();
    `CHK(rises, 8)
    `CHK(m_rx, 8'hc3)
    apb(1'b0, `SPM_OFS_DATA, 32'h0);
    `CHK(rdat[7:0], 8'h3c)
    // Select high output, then multi-master with a competing master
    apb(1'b1, `SPM_OFS_CTRL, 32'h0f);
    repeat (3) @(posedge clk_sys);
    `CHK(pin_o.ss, 1'b1)
    apb(1'b1, `SPM_OFS_CTRL, 32'h07);
    repeat (3) @(posedge clk_sys);
    `CHK(pin_oe_n.ss, 1'b1)
    tb_ss <= 1'b0;
    repeat (6) @(posedge clk_sys);
    apb(1'b0, `SPM_OFS_CTRL, 32'h0);
    `CHK(rdat[7:0], 8'h26)
    apb(1'b0, `SPM_OFS_CFG, 32'h0);
    `CHK(rdat[6], 1'b0)
    // Software re-enables as a 3-wire slave
    tb_ss <= 1'b1;
    apb(1'b1, `SPM_OFS_CFG, 32'h0);
    apb(1'b1, `SPM_OFS_CTRL, 32'h01);
    apb(1'b1, `SPM_OFS_DATA, 32'h5a);
    repeat (3) @(posedge clk_sys);
    `CHK(ss_routed, 1'b0)
    `CHK(pin_oe_n.miso, 1'b0)
    slv_byte(8'h96);
    repeat (6) @(posedge clk_sys);
    `CHK(got, 8'h5a)
    apb(1'b0, `SPM_OFS_DATA, 32'h0);
    `CHK(rdat[7:0], 8'h96)
    // 4-wire slave, not selected, then selected
    apb(1'b1, `SPM_OFS_CTRL, 32'h05);
    repeat (3) @(posedge clk_sys);
    `CHK(pin_oe_n.miso, 1'b1)
    slv_byte(8'hff);
    repeat (6) @(posedge clk_sys);
    apb(1'b0, `SPM_OFS_CTRL, 32'h0);
    `CHK(rdat[7], 1'b0)
    tb_ss <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(pin_oe_n.miso, 1'b0)
    final_report();
  end
endmodule
